// file: pkg/serial_channel_irq_regs.svh
// register offsets, field positions and reset values of the serial channel irq block
`ifndef SERIAL_CHANNEL_IRQ_REGS_SVH
`define SERIAL_CHANNEL_IRQ_REGS_SVH

// byte offsets on the register bus
`define OFS_STATUS0      8'h00
`define OFS_IRQ_EN0      8'h04
`define OFS_TX_FLAGS     8'h08
`define OFS_TX_EN        8'h0c
`define OFS_RX_FLAGS     8'h10
`define OFS_RX_EN        8'h14
`define OFS_FRAME_STAT   8'h18
`define OFS_CONTROL      8'h1c
`define OFS_TX_THRESH    8'h20
`define OFS_COMMAND      8'h24
`define OFS_MODE0        8'h28

// request positions in status0 and irq enable 0
`define BIT_TX_SPACE     7
`define BIT_RX_DATA      6
`define BIT_TX_EVENT     1
`define BIT_RX_EVENT     0

// transmit event flag positions
`define TXF_UNDERRUN     0
`define TXF_QUIESCENT    1
`define TXF_CTS_CHANGE   2
`define TX_FLAG_W        3

// receive event flag positions
`define RXF_SYNC_FLAG    0
`define RXF_CARRIER      1
`define RXF_BREAK_ABORT  2
`define RXF_BREAK_END    3
`define RXF_FRAME_END    4
`define RXF_PARITY_MP    5
`define RXF_PARITY_ABT   6
`define RXF_FRAMING      7
`define RXF_OVERFLOW     8
`define RXF_CHECK        9
`define RXF_LATCHED_END  10
`define RXF_CLOCK_LOSS   11
`define RX_FLAG_W        12
// per-frame group: frame end .. check fault
`define FRAME_LO         4
`define FRAME_HI         9
`define FRAME_W          6

// control register fields
`define CTL_TX_EN        0
`define CTL_RX_EN        1
`define CTL_CHECK_CALC   2
`define CTL_HOST16       3
`define CTL_RTS          4
`define CTL_TXC_OUT      5
`define CTL_RXC_OUT      6
`define CTL_W            7

// command register fields (write only, self clearing)
`define CMD_CHAN_RST     0
`define CMD_TX_RST       1
`define CMD_RX_RST       2

// mode0 fields: [1:0] protocol, [3:2] stop, [5:4] char len, [7:6] clock rate,
// [8] parity, [9] half duplex, [11:10] coding
`define MODE_W           12
`define MODE0_RESET      12'h000
`define TX_LEVEL_W       8
`define THRESH_RESET     8'h00

`endif

// file: pkg/serial_channel_pkg.sv
// types shared by the serial channel irq block
package serial_channel_pkg;
  typedef enum logic [1:0] {
    PROTO_ASYNC,
    PROTO_BYTE_SYNC,
    PROTO_BIT_SYNC
  } proto_mode_t;
endpackage

// file: rtl/sticky_flag_bank.sv
// bank of sticky event flags with hardware set, clears and a flush
`timescale 1ns/1ns
`default_nettype none
module sticky_flag_bank #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controls
  input wire logic flush,
  input wire logic [W-1:0] set_pulse,
  input wire logic [W-1:0] hw_clr,
  input wire logic [W-1:0] sw_clr,
  // state
  output logic [W-1:0] flags
);
  wire [W-1:0] flags_nxt;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      // set beats any clear so a coincident event is never lost; flush beats all
      assign flags_nxt[i] = flush ? 1'b0 :
        (set_pulse[i] | (flags[i] & ~hw_clr[i] & ~sw_clr[i]));
    end
  endgenerate
  // one process owns the whole vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= flags_nxt;
    end
  end
endmodule
`default_nettype wire

// file: rtl/serial_channel_irq_and_reset.sv
// interrupt request, interrupt clearing and reset logic of one serial channel
//
// Behaviour
// - tx space request until level exceeds threshold
// - tx space cleared by channel/tx reset
// - rx data request until buffer empty
// - writing one clears each event flag
// - tx quiescent cleared by writing tx data
// - parity-mp flag clears on zero next byte(s)
// - check fault clears when crc correct
// - bit-sync last read latches frame status
// - rx events cleared by channel/rx reset
// - tx events cleared by channel/tx reset
// - space/data request is flag and enable
// - tx summary ors enabled tx sources
// - rx summary ors twelve enabled sources
// - shared flag positions depend on protocol
// - channel reset disables, flushes, idles pins
// - reset defaults async, 8-bit, nrz, full duplex
// - reset zeroes enables, pin clocks, inits pll
// - requests at status0 bits 7,6,1,0
// - summaries ignore their summary enable bits
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "serial_channel_irq_regs.svh"
module serial_channel_irq_and_reset (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit side status
  input wire logic [`TX_LEVEL_W-1:0] tx_level,
  input wire logic tx_buf_write,
  input wire logic tx_underrun_set,
  input wire logic tx_quiescent_set,
  input wire logic cts_change_set,
  // receive side status
  input wire logic [`RX_FLAG_W-1:0] rx_event_set,
  input wire logic rx_buf_empty,
  input wire logic rx_next_ready,
  input wire logic [1:0] rx_next_pm,
  input wire logic crc_ok,
  input wire logic rx_last_char_read,
  // interrupt requests
  output logic tx_space_irq,
  output logic rx_data_irq,
  output logic tx_event_irq,
  output logic rx_event_irq,
  // channel control
  output logic tx_enable,
  output logic rx_enable,
  output logic tx_flush,
  output logic rx_flush,
  output logic txd_hold_mark,
  output logic rts_n,
  output logic txc_oe,
  output logic rxc_oe,
  output logic dpll_init,
  output logic brg_init,
  // line format
  output var serial_channel_pkg::proto_mode_t proto_mode,
  output logic [1:0] stop_bits,
  output logic [1:0] char_len,
  output logic [1:0] clk_rate,
  output logic parity_en,
  output logic half_duplex,
  output logic [1:0] line_coding
);
  import serial_channel_pkg::*;

  function automatic proto_mode_t to_proto(input logic [1:0] code);
    to_proto = (code == 2'h1) ? PROTO_BYTE_SYNC : (code == 2'h2) ? PROTO_BIT_SYNC : PROTO_ASYNC;
  endfunction

  // ---------------- state ----------------
  logic [3:0] irq_en0_r;
  logic [`TX_FLAG_W-1:0] tx_en_r;
  logic [`RX_FLAG_W-1:0] rx_en_r;
  logic [`CTL_W-1:0] ctl_r;
  logic [`TX_LEVEL_W-1:0] thresh_r;
  logic [`MODE_W-1:0] mode_r;
  logic [`FRAME_W-1:0] frame_stat_r;
  logic chan_rst_r;
  logic tx_rst_r;
  logic rx_rst_r;
  logic tx_space_status_r;
  logic rx_data_status_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic tx_space_irq_r;
  logic rx_data_irq_r;
  logic tx_event_irq_r;
  logic rx_event_irq_r;
  logic [`TX_FLAG_W-1:0] tx_flags;
  logic [`RX_FLAG_W-1:0] rx_flags;

  // ---------------- apb decode ----------------
  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pready_r & pwrite;
  wire sel_st0 = paddr == `OFS_STATUS0;
  wire sel_ie0 = paddr == `OFS_IRQ_EN0;
  wire sel_txf = paddr == `OFS_TX_FLAGS;
  wire sel_txe = paddr == `OFS_TX_EN;
  wire sel_rxf = paddr == `OFS_RX_FLAGS;
  wire sel_rxe = paddr == `OFS_RX_EN;
  wire sel_fst = paddr == `OFS_FRAME_STAT;
  wire sel_ctl = paddr == `OFS_CONTROL;
  wire sel_thr = paddr == `OFS_TX_THRESH;
  wire sel_cmd = paddr == `OFS_COMMAND;
  wire sel_md0 = paddr == `OFS_MODE0;
  wire mapped = sel_st0 | sel_ie0 | sel_txf | sel_txe | sel_rxf | sel_rxe | sel_fst |
                sel_ctl | sel_thr | sel_cmd | sel_md0;
  wire wr_cmd = wr_en & sel_cmd;
  wire chan_cmd = wr_cmd & pwdata[`CMD_CHAN_RST];

  // ---------------- event summaries ----------------
  wire bit_sync = proto_mode == PROTO_BIT_SYNC;
  wire tx_sum = |(tx_flags & tx_en_r);
  // one flag position carries e.g. sync detect or flag detect depending on protocol;
  // the channel presents whichever meaning the current mode gives, so the gate is common
  wire rx_sum = |(rx_flags & rx_en_r);
  wire [7:0] st0_w = {tx_space_status_r, rx_data_status_r, 4'h0, tx_sum, rx_sum};
  wire tx_space_req = tx_space_status_r & irq_en0_r[3];
  wire rx_data_req = rx_data_status_r & irq_en0_r[2];
  wire tx_event_req = tx_sum & irq_en0_r[1];
  wire rx_event_req = rx_sum & irq_en0_r[0];

  // ---------------- flag clear sources ----------------
  wire [`TX_FLAG_W-1:0] tx_sw_clr = (wr_en & sel_txf) ? pwdata[`TX_FLAG_W-1:0] : '0;
  wire [`RX_FLAG_W-1:0] rx_sw_clr = (wr_en & sel_rxf) ? pwdata[`RX_FLAG_W-1:0] : '0;
  wire [`TX_FLAG_W-1:0] tx_set = {cts_change_set, tx_quiescent_set, tx_underrun_set};
  // writing data moves the transmitter out of idle
  wire [`TX_FLAG_W-1:0] tx_hw_clr = {1'b0, tx_buf_write, 1'b0};
  // host16 reads two bytes at once, so both must show a clear parity/mp bit
  wire pm_zero = ctl_r[`CTL_HOST16] ? (rx_next_pm == 2'h0) : ~rx_next_pm[0];
  wire pmp_clr = rx_next_ready & pm_zero;
  wire check_report = ctl_r[`CTL_CHECK_CALC] & ~crc_ok;
  wire frame_copy = bit_sync & rx_last_char_read;
  wire [`RX_FLAG_W-1:0] frame_mask = {2'h0, {`FRAME_W{frame_copy}}, 4'h0};
  wire [`RX_FLAG_W-1:0] rx_hw_clr = frame_mask | (`RX_FLAG_W'(pmp_clr) << `RXF_PARITY_MP) |
    (`RX_FLAG_W'(crc_ok) << `RXF_CHECK);
  wire latch_end = frame_copy & rx_flags[`RXF_FRAME_END];
  wire [`RX_FLAG_W-1:0] rx_set = rx_event_set | (`RX_FLAG_W'(check_report) << `RXF_CHECK) |
    (`RX_FLAG_W'(latch_end) << `RXF_LATCHED_END);

  sticky_flag_bank #(.W(`TX_FLAG_W)) u_tx_flags (
    .pclk(pclk),
    .presetn(presetn),
    .flush(tx_rst_r),
    .set_pulse(tx_set),
    .hw_clr(tx_hw_clr),
    .sw_clr(tx_sw_clr),
    .flags(tx_flags)
  );

  sticky_flag_bank #(.W(`RX_FLAG_W)) u_rx_flags (
    .pclk(pclk),
    .presetn(presetn),
    .flush(rx_rst_r),
    .set_pulse(rx_set),
    .hw_clr(rx_hw_clr),
    .sw_clr(rx_sw_clr),
    .flags(rx_flags)
  );

  // ---------------- read mux ----------------
  wire [31:0] rd_mux =
    sel_st0 ? {24'h0, st0_w} :
    sel_ie0 ? {24'h0, irq_en0_r[3:2], 4'h0, irq_en0_r[1:0]} :
    sel_txf ? {29'h0, tx_flags} :
    sel_txe ? {29'h0, tx_en_r} :
    sel_rxf ? {20'h0, rx_flags} :
    sel_rxe ? {20'h0, rx_en_r} :
    sel_fst ? {26'h0, frame_stat_r} :
    sel_ctl ? {25'h0, ctl_r} :
    sel_thr ? {24'h0, thresh_r} :
    sel_md0 ? {20'h0, mode_r} : 32'h0;

  // one wait-free access: pready rises in the access phase after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & ~mapped;
      prdata_r <= (setup_ph & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // ---------------- command pulses ----------------
  // a channel reset implies both direction resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_rst_r <= 1'b0;
      tx_rst_r <= 1'b0;
      rx_rst_r <= 1'b0;
    end else begin
      chan_rst_r <= chan_cmd;
      tx_rst_r <= wr_cmd & (pwdata[`CMD_CHAN_RST] | pwdata[`CMD_TX_RST]);
      rx_rst_r <= wr_cmd & (pwdata[`CMD_CHAN_RST] | pwdata[`CMD_RX_RST]);
    end
  end

  // ---------------- software registers ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en0_r <= 4'h0;
      tx_en_r <= '0;
      rx_en_r <= '0;
      thresh_r <= `THRESH_RESET;
      mode_r <= `MODE0_RESET;
    end else if (chan_rst_r) begin
      irq_en0_r <= 4'h0;
      tx_en_r <= '0;
      rx_en_r <= '0;
      thresh_r <= `THRESH_RESET;
      mode_r <= `MODE0_RESET;
    end else if (wr_en) begin
      if (sel_ie0) begin
        irq_en0_r <= {pwdata[`BIT_TX_SPACE], pwdata[`BIT_RX_DATA],
                      pwdata[`BIT_TX_EVENT], pwdata[`BIT_RX_EVENT]};
      end
      if (sel_txe) begin
        tx_en_r <= pwdata[`TX_FLAG_W-1:0];
      end
      if (sel_rxe) begin
        rx_en_r <= pwdata[`RX_FLAG_W-1:0];
      end
      if (sel_thr) begin
        thresh_r <= pwdata[`TX_LEVEL_W-1:0];
      end
      if (sel_md0) begin
        mode_r <= pwdata[`MODE_W-1:0];
      end
    end
  end

  // direction resets also stop their direction; the channel reset clears everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= '0;
    end else if (chan_rst_r) begin
      ctl_r <= '0;
    end else begin
      if (wr_en & sel_ctl) begin
        ctl_r <= pwdata[`CTL_W-1:0];
      end
      if (tx_rst_r) begin
        ctl_r[`CTL_TX_EN] <= 1'b0;
      end
      if (rx_rst_r) begin
        ctl_r[`CTL_RX_EN] <= 1'b0;
      end
    end
  end

  // ---------------- frame status ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_stat_r <= '0;
    end else if (chan_rst_r) begin
      frame_stat_r <= '0;
    end else if (frame_copy) begin
      frame_stat_r <= rx_flags[`FRAME_HI:`FRAME_LO];
    end
  end

  // ---------------- request status ----------------
  // space is asserted while the transmitter is enabled and the level is at or below the threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_space_status_r <= 1'b0;
      rx_data_status_r <= 1'b0;
    end else begin
      tx_space_status_r <= ctl_r[`CTL_TX_EN] & ~tx_rst_r & (tx_level <= thresh_r);
      rx_data_status_r <= ~rx_rst_r & ~rx_buf_empty;
    end
  end

  // levels, one cycle behind their causes so that every output leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_space_irq_r <= 1'b0;
      rx_data_irq_r <= 1'b0;
      tx_event_irq_r <= 1'b0;
      rx_event_irq_r <= 1'b0;
    end else begin
      tx_space_irq_r <= tx_space_req;
      rx_data_irq_r <= rx_data_req;
      tx_event_irq_r <= tx_event_req;
      rx_event_irq_r <= rx_event_req;
    end
  end

  // ---------------- outputs ----------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_space_irq = tx_space_irq_r;
  assign rx_data_irq = rx_data_irq_r;
  assign tx_event_irq = tx_event_irq_r;
  assign rx_event_irq = rx_event_irq_r;
  assign tx_enable = ctl_r[`CTL_TX_EN];
  assign rx_enable = ctl_r[`CTL_RX_EN];
  assign tx_flush = tx_rst_r;
  assign rx_flush = rx_rst_r;
  assign dpll_init = chan_rst_r;
  assign brg_init = chan_rst_r;
  // data out rests at mark whenever the transmitter is off
  assign txd_hold_mark = ~ctl_r[`CTL_TX_EN];
  assign rts_n = ~ctl_r[`CTL_RTS];
  assign txc_oe = ctl_r[`CTL_TXC_OUT];
  assign rxc_oe = ctl_r[`CTL_RXC_OUT];
  assign proto_mode = to_proto(mode_r[1:0]);
  assign stop_bits = mode_r[3:2];
  assign char_len = mode_r[5:4];
  assign clk_rate = mode_r[7:6];
  assign parity_en = mode_r[8];
  assign half_duplex = mode_r[9];
  assign line_coding = mode_r[11:10];

  // ---------------- checks ----------------
  chk_space_level: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_level > thresh_r) |=> !tx_space_status_r)
    else $error("tx space status high above threshold");

  chk_space_reset: assert property (@(posedge pclk) disable iff (!presetn)
    tx_rst_r |-> ##2 !tx_space_status_r && !tx_enable)
    else $error("tx space status survived tx reset");

  chk_rx_empty: assert property (@(posedge pclk) disable iff (!presetn)
    rx_buf_empty |=> !rx_data_status_r)
    else $error("rx data status high with empty buffer");

  chk_write_one: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel_txf && pwdata[`TXF_UNDERRUN] && !tx_underrun_set && !tx_rst_r)
    |=> !tx_flags[`TXF_UNDERRUN])
    else $error("underrun flag not cleared by write one");

  chk_quiescent_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_buf_write && !tx_quiescent_set) |=> !tx_flags[`TXF_QUIESCENT])
    else $error("quiescent flag kept after tx write");

  chk_pmp_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_next_ready && ctl_r[`CTL_HOST16] && rx_next_pm != 2'h0 &&
     !rx_event_set[`RXF_PARITY_MP] && rx_flags[`RXF_PARITY_MP] && !rx_sw_clr[`RXF_PARITY_MP] &&
     !rx_rst_r && !frame_copy) |=> rx_flags[`RXF_PARITY_MP])
    else $error("parity-mp flag cleared with a set bit pending");

  chk_check_report: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl_r[`CTL_CHECK_CALC] && !crc_ok && !rx_rst_r) |=> rx_flags[`RXF_CHECK])
    else $error("check fault flag not reporting crc result");

  chk_frame_copy: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_copy && !chan_rst_r) |=> frame_stat_r == $past(rx_flags[`FRAME_HI:`FRAME_LO]))
    else $error("frame status not latched on last read");

  chk_event_irq: assert property (@(posedge pclk) disable iff (!presetn)
    tx_event_req |=> tx_event_irq ##0 $past(tx_sum))
    else $error("tx event request not raised");

  chk_chan_reset: assert property (@(posedge pclk) disable iff (!presetn)
    chan_rst_r |=> !tx_enable && !rx_enable && !txc_oe && rts_n && mode_r == `MODE0_RESET)
    else $error("channel reset left channel active");
endmodule
`default_nettype wire

// file: test/channel_model.sv
// behavioural model of the serial channel that feeds status into the irq block
`timescale 1ns/1ns
`default_nettype none
`include "serial_channel_irq_regs.svh"
module channel_model (
  // clock
  input wire logic pclk,
  // channel status toward the block
  output logic [`TX_LEVEL_W-1:0] tx_level,
  output logic tx_buf_write,
  output logic tx_underrun_set,
  output logic tx_quiescent_set,
  output logic cts_change_set,
  output logic [`RX_FLAG_W-1:0] rx_event_set,
  output logic rx_buf_empty,
  output logic rx_next_ready,
  output logic [1:0] rx_next_pm,
  output logic crc_ok,
  output logic rx_last_char_read
);
  initial begin
    {tx_level, tx_buf_write, tx_underrun_set, tx_quiescent_set, cts_change_set} = '0;
    {rx_event_set, rx_next_ready, rx_next_pm, rx_last_char_read} = '0;
    rx_buf_empty = 1'b1;
    crc_ok = 1'b1;
  end
  // sel: 0 underrun, 1 quiescent, 2 cts change, 3 byte into tx buffer
  task automatic tx_pulse(input int sel);
    @(posedge pclk);
    tx_underrun_set <= (sel == 0);
    tx_quiescent_set <= (sel == 1);
    cts_change_set <= (sel == 2);
    tx_buf_write <= (sel == 3);
    @(posedge pclk);
    {tx_underrun_set, tx_quiescent_set, cts_change_set, tx_buf_write} <= 4'h0;
  endtask
  // strobes last one cycle; nothing pulses twice in a row, so flags see clean edges
  task automatic rx_pulse(input logic [11:0] set, input logic nxt, input logic [1:0] pm,
                          input logic last);
    @(posedge pclk);
    rx_event_set <= set;
    rx_next_ready <= nxt;
    rx_next_pm <= pm;
    rx_last_char_read <= last;
    @(posedge pclk);
    rx_event_set <= '0;
    rx_next_ready <= 1'b0;
    rx_next_pm <= ~pm;
    rx_last_char_read <= 1'b0;
  endtask
  task automatic set_levels(input logic [7:0] lvl, input logic empty, input logic ok);
    @(posedge pclk);
    tx_level <= lvl;
    rx_buf_empty <= empty;
    crc_ok <= ok;
  endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the serial channel irq and reset block
`timescale 1ns/1ns
`default_nettype none
`include "serial_channel_irq_regs.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_last;
  logic pready, pslverr, err_last;
  logic [`TX_LEVEL_W-1:0] tx_level;
  logic tx_buf_write, tx_underrun_set, tx_quiescent_set, cts_change_set;
  logic [`RX_FLAG_W-1:0] rx_event_set;
  logic rx_buf_empty, rx_next_ready, crc_ok, rx_last_char_read;
  logic [1:0] rx_next_pm;
  logic tx_space_irq, rx_data_irq, tx_event_irq, rx_event_irq;
  logic tx_enable, rx_enable, txd_hold_mark, rts_n, txc_oe, rxc_oe;
  logic tx_flush, rx_flush, dpll_init, brg_init, parity_en, half_duplex;
  logic [1:0] proto_mode, stop_bits, char_len, clk_rate, line_coding;
  int errors, samples_checked, cycles;

  channel_model u_channel_model (.pclk(pclk), .tx_level(tx_level),
    .tx_buf_write(tx_buf_write), .tx_underrun_set(tx_underrun_set),
    .tx_quiescent_set(tx_quiescent_set), .cts_change_set(cts_change_set),
    .rx_event_set(rx_event_set), .rx_buf_empty(rx_buf_empty), .rx_next_ready(rx_next_ready),
    .rx_next_pm(rx_next_pm), .crc_ok(crc_ok), .rx_last_char_read(rx_last_char_read));

  serial_channel_irq_and_reset u_serial_channel_irq_and_reset (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_level(tx_level),
    .tx_buf_write(tx_buf_write), .tx_underrun_set(tx_underrun_set),
    .tx_quiescent_set(tx_quiescent_set), .cts_change_set(cts_change_set),
    .rx_event_set(rx_event_set), .rx_buf_empty(rx_buf_empty), .rx_next_ready(rx_next_ready),
    .rx_next_pm(rx_next_pm), .crc_ok(crc_ok), .rx_last_char_read(rx_last_char_read),
    .tx_space_irq(tx_space_irq), .rx_data_irq(rx_data_irq), .tx_event_irq(tx_event_irq),
    .rx_event_irq(rx_event_irq), .tx_enable(tx_enable), .rx_enable(rx_enable),
    .tx_flush(tx_flush), .rx_flush(rx_flush), .txd_hold_mark(txd_hold_mark), .rts_n(rts_n),
    .txc_oe(txc_oe), .rxc_oe(rxc_oe), .dpll_init(dpll_init), .brg_init(brg_init),
    .proto_mode(proto_mode), .stop_bits(stop_bits), .char_len(char_len), .clk_rate(clk_rate),
    .parity_en(parity_en), .half_duplex(half_duplex), .line_coding(line_coding));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // a hang is cut short well beyond the few hundred cycles the sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_last = prdata;
    err_last = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_last, exp);
  endtask

  // irq outputs lag flag and enable by a cycle, so let them settle
  task automatic irq_chk(input logic [3:0] exp);
    repeat (3) @(posedge pclk);
    chk({28'h0, tx_space_irq, rx_data_irq, tx_event_irq, rx_event_irq}, {28'h0, exp});
  endtask

  task automatic pins_chk();
    chk({26'h0, rts_n, txd_hold_mark, tx_enable, rx_enable, txc_oe, rxc_oe}, 32'h30);
  endtask

  // line format outputs packed in mode0 field order
  task automatic fmt_chk(input logic [31:0] exp);
    chk({20'h0, line_coding, half_duplex, parity_en, clk_rate, char_len, stop_bits,
         proto_mode}, exp);
  endtask

  task automatic t_reset();
    pins_chk();
    fmt_chk(32'h0);
    rd_chk(`OFS_CONTROL, 32'h0);
    rd_chk(`OFS_MODE0, {20'h0, `MODE0_RESET});
    rd_chk(`OFS_IRQ_EN0, 32'h0);
    rd_chk(`OFS_STATUS0, 32'h0);
  endtask

  task automatic t_tx_events();
    u_channel_model.tx_pulse(0);
    rd_chk(`OFS_TX_FLAGS, 32'h1);
    rd_chk(`OFS_STATUS0, 32'h0);
    wr(`OFS_TX_EN, 32'h7);
    rd_chk(`OFS_STATUS0, 32'h2);
    irq_chk(4'b0000);
    wr(`OFS_IRQ_EN0, 32'h2);
    irq_chk(4'b0010);
    wr(`OFS_TX_FLAGS, 32'h1);
    rd_chk(`OFS_TX_FLAGS, 32'h0);
    irq_chk(4'b0000);
    u_channel_model.tx_pulse(1);
    rd_chk(`OFS_TX_FLAGS, 32'h2);
    u_channel_model.tx_pulse(3);
    rd_chk(`OFS_TX_FLAGS, 32'h0);
    u_channel_model.tx_pulse(2);
    rd_chk(`OFS_TX_FLAGS, 32'h4);
    wr(`OFS_COMMAND, 32'h2);
    rd_chk(`OFS_TX_FLAGS, 32'h0);
  endtask

  task automatic t_rx_events();
    // a good running crc would wipe the check fault flag a cycle after it is set
    u_channel_model.set_levels(8'h00, 1'b1, 1'b0);
    u_channel_model.rx_pulse(12'hfff, 1'b0, 2'b00, 1'b0);
    rd_chk(`OFS_RX_FLAGS, 32'hfff);
    wr(`OFS_RX_EN, 32'h800);
    wr(`OFS_IRQ_EN0, 32'h1);
    irq_chk(4'b0001);
    wr(`OFS_RX_FLAGS, 32'h800);
    rd_chk(`OFS_STATUS0, 32'h0);
    wr(`OFS_COMMAND, 32'h4);
    rd_chk(`OFS_RX_FLAGS, 32'h0);
  endtask

  task automatic t_tx_space();
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_TX_THRESH, 32'h4);
    u_channel_model.set_levels(8'h04, 1'b1, 1'b1);
    wr(`OFS_IRQ_EN0, 32'h80);
    rd_chk(`OFS_STATUS0, 32'h80);
    irq_chk(4'b1000);
    u_channel_model.set_levels(8'h05, 1'b1, 1'b1);
    rd_chk(`OFS_STATUS0, 32'h0);
    u_channel_model.set_levels(8'h00, 1'b1, 1'b1);
    rd_chk(`OFS_STATUS0, 32'h80);
    wr(`OFS_CONTROL, 32'h0);
    rd_chk(`OFS_STATUS0, 32'h0);
    wr(`OFS_CONTROL, 32'h1);
    rd_chk(`OFS_STATUS0, 32'h80);
    wr(`OFS_COMMAND, 32'h2);
    rd_chk(`OFS_STATUS0, 32'h0);
  endtask

  task automatic t_rx_data();
    u_channel_model.set_levels(8'h00, 1'b0, 1'b1);
    wr(`OFS_IRQ_EN0, 32'h40);
    rd_chk(`OFS_STATUS0, 32'h40);
    irq_chk(4'b0100);
    u_channel_model.set_levels(8'h00, 1'b1, 1'b1);
    rd_chk(`OFS_STATUS0, 32'h0);
  endtask

  task automatic t_rx_clears();
    wr(`OFS_CONTROL, 32'h8);
    u_channel_model.rx_pulse(12'h020, 1'b0, 2'b00, 1'b0);
    u_channel_model.rx_pulse(12'h000, 1'b1, 2'b10, 1'b0);
    rd_chk(`OFS_RX_FLAGS, 32'h20);
    u_channel_model.rx_pulse(12'h000, 1'b1, 2'b00, 1'b0);
    rd_chk(`OFS_RX_FLAGS, 32'h0);
    // 8-bit host: only the low parity bit of the next data matters
    wr(`OFS_CONTROL, 32'h0);
    u_channel_model.rx_pulse(12'h020, 1'b0, 2'b00, 1'b0);
    u_channel_model.rx_pulse(12'h000, 1'b1, 2'b10, 1'b0);
    rd_chk(`OFS_RX_FLAGS, 32'h0);
    u_channel_model.set_levels(8'h00, 1'b1, 1'b0);
    wr(`OFS_CONTROL, 32'h4);
    rd_chk(`OFS_RX_FLAGS, 32'h200);
    u_channel_model.set_levels(8'h00, 1'b1, 1'b1);
    rd_chk(`OFS_RX_FLAGS, 32'h0);
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_MODE0, 32'h2);
    u_channel_model.rx_pulse(12'h010, 1'b0, 2'b00, 1'b0);
    u_channel_model.rx_pulse(12'h000, 1'b0, 2'b00, 1'b1);
    rd_chk(`OFS_FRAME_STAT, 32'h1);
    rd_chk(`OFS_RX_FLAGS, 32'h400);
    fmt_chk(32'h2);
  endtask

  task automatic t_chan_reset();
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, err_last}, 32'h1);
    wr(`OFS_CONTROL, 32'h7f);
    wr(`OFS_COMMAND, 32'h1);
    @(posedge pclk);
    chk({28'h0, tx_flush, rx_flush, dpll_init, brg_init}, 32'hf);
    @(posedge pclk);
    pins_chk();
    fmt_chk(32'h0);
    rd_chk(`OFS_CONTROL, 32'h0);
    rd_chk(`OFS_MODE0, 32'h0);
    rd_chk(`OFS_IRQ_EN0, 32'h0);
    rd_chk(`OFS_RX_FLAGS, 32'h0);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {errors, samples_checked, cycles} = '0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx_events();
    t_rx_events();
    t_tx_space();
    t_rx_data();
    t_rx_clears();
    t_chan_reset();
    summarize();
  end
endmodule
`default_nettype wire
